// ==== test/smc_standby_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module smc_standby_ctrl_tb
	import smc_pkg::*;
;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, dly;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, halt_exec;
	logic        wdt_run_bit, wake_edge_select, wdt_overflow_flag, nmi_pin, external_reset_pin_n, nmi_exception_q;
	smc_power_t  power_q;
	smc_init_t   init_q, init_seen;
	smc_reset_t  reset_req_q;
	int          err_total, check_count, nmi_cnt, por_cnt, man_cnt;

	smc_standby_ctrl smc_standby_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.halt_exec, .wdt_run_bit, .wake_edge_select, .wdt_overflow_flag, .nmi_pin, .external_reset_pin_n,
		.power_q, .init_q, .reset_req_q, .nmi_exception_q);
	smc_wdt_model smc_wdt_model_i (.aclk, .aresetn, .power(power_q), .dly, .wdt_overflow_flag);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Pulses last one cycle, so they are caught here and judged later
	always @(posedge aclk) begin
		if (init_q !== 6'h00) init_seen <= init_q;
		if (nmi_exception_q === 1'b1) nmi_cnt++;
		if (reset_req_q.power_on === 1'b1) por_cnt++;
		if (reset_req_q.manual === 1'b1) man_cnt++;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [31:0] exp_ctrl(input logic s, input logic f);
		return {24'h000000, s, f, 6'h1F};
	endfunction

	// State code: 0 run, 1 standby, 2 settle; settling is still standby, so ports keep the float bit setting
	function automatic smc_power_t exp_pw(input logic [1:0] st, input logic f);
		case (st)
			2'h0: return 5'h1E;
			2'h1: return {4'h0, f};
			default: return {3'h0, 1'b1, f};
		endcase
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// No fixed wait: only the watchdog ends a hung transfer
		forever begin
			@(posedge aclk);
			if (aw && w && s_axi_bvalid === 1'b1) break;
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, SMC_RESP_OKAY)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, er)
	endtask

	task automatic wait_pw(input smc_power_t e, input int n);
		repeat (n) begin
			@(posedge aclk);
			if (power_q === e) break;
		end
		`CHK(power_q, e)
		// Pulse catchers update at this same edge; one more edge lets them settle
		@(posedge aclk);
	endtask

	task automatic halt;
		@(posedge aclk);
		halt_exec <= 1'b1;
		@(posedge aclk);
		halt_exec <= 1'b0;
	endtask

	// Pin level n is settled through the synchronisers before the halt
	task automatic enter(input logic k, input logic f, input logic n);
		wr(8'h00, {24'h000000, 1'b1, f, 6'h00});
		wake_edge_select <= k;
		nmi_pin <= n;
		cyc(6);
		init_seen = 6'h00;
		halt;
		wait_pw(exp_pw(2'h1, f), 3);
		`CHK(init_seen, 6'h3F)
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge aclk);
		err_total++;
		finish_test;
	end

	initial begin
		seed = 32'h0000295C;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, halt_exec, wdt_run_bit, wake_edge_select} = '0;
		s_axi_wstrb = 4'hF;
		nmi_pin = 1'b1;
		external_reset_pin_n = 1'b1;
		dly = 8'h01;
		aresetn = 1'b0;
		cyc(6);
		aresetn <= 1'b1;
		rd_chk(8'h00, exp_ctrl(1'b0, 1'b0), SMC_RESP_OKAY);
		rd_chk(8'h40, 32'h00000000, SMC_RESP_SLVERR);
		wdt_run_bit <= 1'b1;
		wr(8'h00, 32'h000000C0);
		rd_chk(8'h00, exp_ctrl(1'b0, 1'b0), SMC_RESP_OKAY);
		wdt_run_bit <= 1'b0;
		seed = xs(seed);
		wr(8'h04, seed);
		wr(8'h00, 32'h000000C0);
		rd_chk(8'h00, exp_ctrl(1'b1, 1'b1), SMC_RESP_OKAY);
		// Falling wake first, then rising wake with floated ports
		for (int k = 0; k < 2; k++) begin
			seed = xs(seed);
			dly <= {5'h00, seed[2:0]} + 8'h01;
			// pin sits opposite to the wake edge at entry
			enter(k[0], k[0], !k[0]);
			nmi_pin <= k[0];
			wait_pw(exp_pw(2'h2, k[0]), 8);
			wait_pw(exp_pw(2'h0, 1'b0), 14);
			`CHK(nmi_cnt, k + 1)
			rd_chk(8'h00, exp_ctrl(1'b1, k[0]), SMC_RESP_OKAY);
			rd_chk(8'h04, {27'h0000000, k[0], k[0], 3'h1}, SMC_RESP_OKAY);
		end
		// Rising pin edge while falling is selected must not wake
		enter(1'b0, 1'b0, 1'b0);
		nmi_pin <= 1'b1;
		cyc(12);
		`CHK(power_q, exp_pw(2'h1, 1'b0))
		external_reset_pin_n <= 1'b0;
		wait_pw(exp_pw(2'h0, 1'b0), 10);
		`CHK(por_cnt, 1)
		external_reset_pin_n <= 1'b1;
		nmi_pin <= 1'b0;
		cyc(6);
		enter(1'b1, 1'b0, 1'b0);
		external_reset_pin_n <= 1'b0;
		wait_pw(exp_pw(2'h0, 1'b0), 10);
		`CHK(man_cnt, 1)
		`CHK(por_cnt + nmi_cnt, 3)
		external_reset_pin_n <= 1'b1;
		cyc(6);
		wr(8'h00, 32'h00000000);
		halt;
		cyc(4);
		`CHK(power_q, exp_pw(2'h0, 1'b0))
		finish_test;
	end
endmodule
`default_nettype wire

// ==== test/smc_wdt_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module smc_wdt_model
	import smc_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire smc_power_t power,
	input  wire logic [7:0] dly,
	output logic            wdt_overflow_flag
);
	logic [7:0] cnt_q;
	// counts only while the watchdog alone is clocked
	always_ff @(posedge aclk) begin
		if (!aresetn || !power.wdt_clk_run || power.sys_clk_run) begin
			cnt_q <= 8'h00;
		end else if (cnt_q != 8'hFF) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	// dly stands for a settle interval chosen long enough
	assign wdt_overflow_flag = (cnt_q >= dly) && power.wdt_clk_run && !power.sys_clk_run;
endmodule
`default_nettype wire

// ==== verilog/smc_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module smc_pin_sync
	import smc_pkg::*;
#(
	parameter int               WIDTH     = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] ff1_q;
	logic [WIDTH-1:0] ff2_q;
	logic [WIDTH-1:0] ff3_q;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] stable_d;

	// A bit changes only once stages two and three agree
	always_comb begin
		stable_d = (ff2_q & ff3_q) | (stable_q & (ff2_q ^ ff3_q));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ff1_q    <= RESET_VAL;
			ff2_q    <= RESET_VAL;
			ff3_q    <= RESET_VAL;
			stable_q <= RESET_VAL;
		end else begin
			ff1_q    <= pin_in;
			ff2_q    <= ff1_q;
			ff3_q    <= ff2_q;
			stable_q <= stable_d;
		end
	end

	assign level_out = stable_q;
endmodule
`default_nettype wire

// ==== verilog/smc_pkg.sv ====
`default_nettype none
package smc_pkg;
	localparam int             SMC_ADDR_W      = 8;
	localparam logic [7:0]     SMC_OFS_CTRL    = 8'h00;
	localparam logic [7:0]     SMC_OFS_STAT    = 8'h04;
	localparam int             SMC_BIT_SBY     = 7;
	localparam int             SMC_BIT_FLOAT   = 6;
	localparam logic [5:0]     SMC_RSVD_RD     = 6'h1F;
	localparam logic [1:0]     SMC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]     SMC_RESP_SLVERR = 2'h2;
	localparam int             SMC_SYNC_STAGES = 3;
	localparam logic [1:0]     SMC_PIN_IDLE    = 2'h3;
	localparam logic [2:0]     SMC_STAT_RSVD   = 3'h0;
	localparam logic [23:0]    SMC_UPPER_ZERO  = 24'h000000;

	typedef enum logic [2:0] {
		SMC_RUN     = 3'h1,
		SMC_STANDBY = 3'h2,
		SMC_SETTLE  = 3'h4
	} smc_state_t;

	typedef struct packed {
		logic standby_select_bit;
		logic port_float_bit;
	} smc_ctrl_t;

	typedef struct packed {
		logic cpu_run;
		logic sys_clk_run;
		logic module_clk_run;
		logic wdt_clk_run;
		logic port_float;
	} smc_power_t;

	typedef struct packed {
		logic dma_unit;
		logic pulse_timer_unit;
		logic adc_unit;
		logic serial_unit;
		logic wdt_status_hi;
		logic wdt_reset_status_reg;
	} smc_init_t;

	typedef struct packed {
		logic power_on;
		logic manual;
	} smc_reset_t;

	localparam smc_ctrl_t  SMC_CTRL_RESET  = '{standby_select_bit: 1'b0, port_float_bit: 1'b0};
	localparam smc_power_t SMC_POWER_RESET = '{cpu_run: 1'b1, sys_clk_run: 1'b1, module_clk_run: 1'b1,
	                                           wdt_clk_run: 1'b1, port_float: 1'b0};
endpackage
`default_nettype wire

// ==== verilog/smc_standby_ctrl.sv ====
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Halt with standby select enters standby
// - Standby stops CPU, clock and modules
// - CPU registers and RAM are kept
// - Ports hold or float per float bit
// - Listed units keep their registers
// - DMA, timer, ADC, serial registers reset
// - Watchdog status high bits, reset status cleared
// - Standby control register keeps its contents
// - Only interrupt pin or reset wakes
// - Wake edge restarts clock, watchdog only
// - Watchdog overflow resumes chip, runs interrupt
// - Reset with pin high gives power-on
// - Reset with pin low gives manual
// - Falling select ignores rising pin edge
// - Falling pin edge wakes via interrupt path
// - Edge select 0 falling, 1 rising
// - Standby select refused while watchdog runs
// - Float bit 1 floats ports in standby
module smc_standby_ctrl
	import smc_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [SMC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [SMC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  halt_exec,
	input  wire logic                  wdt_run_bit,
	input  wire logic                  wake_edge_select,
	input  wire logic                  wdt_overflow_flag,
	input  wire logic                  nmi_pin,
	input  wire logic                  external_reset_pin_n,
	output smc_power_t                 power_q,
	output smc_init_t                  init_q,
	output smc_reset_t                 reset_req_q,
	output logic                       nmi_exception_q
);
	smc_state_t             state_q;
	smc_state_t             state_d;
	smc_power_t             power_d;
	smc_init_t              init_d;
	smc_reset_t             reset_req_d;
	logic                   nmi_exception_d;
	logic                   edge_sel_q;
	logic                   edge_sel_d;
	logic                   nmi_prev_q;
	smc_ctrl_t              ctrl_q;
	smc_ctrl_t              ctrl_d;
	logic [1:0]             pin_lvl;
	logic                   nmi_lvl;
	logic                   rst_lvl_n;
	logic                   nmi_rise;
	logic                   nmi_fall;
	logic                   wake_edge;
	logic                   aw_hold_q;
	logic                   aw_hold_d;
	logic [SMC_ADDR_W-1:0]  aw_addr_q;
	logic [SMC_ADDR_W-1:0]  aw_addr_d;
	logic                   w_hold_q;
	logic                   w_hold_d;
	logic [31:0]            w_data_q;
	logic [31:0]            w_data_d;
	logic                   w_lane0_q;
	logic                   w_lane0_d;
	logic                   awready_d;
	logic                   wready_d;
	logic                   bvalid_d;
	logic [1:0]             bresp_d;
	logic                   arready_d;
	logic                   rvalid_d;
	logic [31:0]            rdata_d;
	logic [1:0]             rresp_d;
	logic                   commit;
	logic [7:0]             ctrl_rd;
	logic [7:0]             stat_rd;

	smc_pin_sync #(
		.WIDTH     (2),
		.RESET_VAL (SMC_PIN_IDLE)
	) u_pin_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_in    ({nmi_pin, external_reset_pin_n}),
		.level_out (pin_lvl)
	);

	assign nmi_lvl   = pin_lvl[1];
	assign rst_lvl_n = pin_lvl[0];
	assign nmi_rise  = nmi_lvl & ~nmi_prev_q;
	assign nmi_fall  = ~nmi_lvl & nmi_prev_q;
	// falling select never takes a rising edge
	// falling edge wakes through interrupt path
	assign wake_edge = edge_sel_q ? nmi_rise : nmi_fall;

	// Sequencer
	always_comb begin
		state_d         = state_q;
		init_d          = '0;
		reset_req_d     = '0;
		nmi_exception_d = 1'b0;
		edge_sel_d      = edge_sel_q;
		case (state_q)
			SMC_RUN: begin
				// halt with select bit enters standby
				if (halt_exec && ctrl_q.standby_select_bit) begin
					state_d    = SMC_STANDBY;
					edge_sel_d = wake_edge_select;
					// watchdog upper status and reset status
					// retained units get no init pulse
					init_d     = '1;
				end
			end
			SMC_STANDBY: begin
				if (!rst_lvl_n) begin
					state_d              = SMC_RUN;
					reset_req_d.power_on = nmi_lvl;
					reset_req_d.manual   = ~nmi_lvl;
				end else if (wake_edge) begin
					state_d = SMC_SETTLE;
				end
			end
			SMC_SETTLE: begin
				if (!rst_lvl_n) begin
					state_d              = SMC_RUN;
					reset_req_d.power_on = nmi_lvl;
					reset_req_d.manual   = ~nmi_lvl;
				end else if (wdt_overflow_flag) begin
					state_d         = SMC_RUN;
					nmi_exception_d = 1'b1;
				end
			end
			default: begin
				state_d = SMC_RUN;
			end
		endcase
		// CPU is stopped, never reset, so its state stays
		power_d.cpu_run        = (state_d == SMC_RUN);
		power_d.sys_clk_run    = (state_d == SMC_RUN);
		power_d.module_clk_run = (state_d == SMC_RUN);
		// only the watchdog clocks while settling
		power_d.wdt_clk_run    = (state_d != SMC_STANDBY);
		power_d.port_float     = (state_d != SMC_RUN) && ctrl_q.port_float_bit;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q         <= SMC_RUN;
			power_q         <= SMC_POWER_RESET;
			init_q          <= '0;
			reset_req_q     <= '0;
			nmi_exception_q <= 1'b0;
			edge_sel_q      <= 1'b0;
			nmi_prev_q      <= 1'b1;
		end else begin
			state_q         <= state_d;
			power_q         <= power_d;
			init_q          <= init_d;
			reset_req_q     <= reset_req_d;
			nmi_exception_q <= nmi_exception_d;
			edge_sel_q      <= edge_sel_d;
			nmi_prev_q      <= nmi_lvl;
		end
	end

	// Register slave; CPU is halted in standby so control writes outside run are acknowledged and dropped
	assign commit  = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign ctrl_rd = {ctrl_q.standby_select_bit, ctrl_q.port_float_bit, SMC_RSVD_RD};
	assign stat_rd = {SMC_STAT_RSVD, edge_sel_q, nmi_lvl, state_q};

	always_comb begin
		aw_hold_d = aw_hold_q;
		aw_addr_d = aw_addr_q;
		w_hold_d  = w_hold_q;
		w_data_d  = w_data_q;
		w_lane0_d = w_lane0_q;
		bvalid_d  = s_axi_bvalid;
		bresp_d   = s_axi_bresp;
		ctrl_d    = ctrl_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_d  = 1'b1;
			w_data_d  = s_axi_wdata;
			w_lane0_d = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (commit) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = SMC_RESP_OKAY;
			if (aw_addr_q == SMC_OFS_CTRL) begin
				// register is only changed by software while running
				if (w_lane0_q && state_q == SMC_RUN) begin
					// setting is refused while the watchdog runs
					ctrl_d.standby_select_bit = w_data_q[SMC_BIT_SBY] &
					                            (~wdt_run_bit | ctrl_q.standby_select_bit);
					ctrl_d.port_float_bit     = w_data_q[SMC_BIT_FLOAT] &
					                            (~wdt_run_bit | ctrl_q.port_float_bit);
				end
			end else if (aw_addr_q != SMC_OFS_STAT) begin
				bresp_d = SMC_RESP_SLVERR;
			end
		end
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d  = !w_hold_d && !bvalid_d;
	end

	always_comb begin
		rvalid_d = s_axi_rvalid;
		rdata_d  = s_axi_rdata;
		rresp_d  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = SMC_RESP_OKAY;
			if (s_axi_araddr == SMC_OFS_CTRL) begin
				rdata_d = {SMC_UPPER_ZERO, ctrl_rd};
			end else if (s_axi_araddr == SMC_OFS_STAT) begin
				rdata_d = {SMC_UPPER_ZERO, stat_rd};
			end else begin
				rdata_d = '0;
				rresp_d = SMC_RESP_SLVERR;
			end
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			aw_addr_q     <= '0;
			w_hold_q      <= 1'b0;
			w_data_q      <= '0;
			w_lane0_q     <= 1'b0;
			ctrl_q        <= SMC_CTRL_RESET;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= SMC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= SMC_RESP_OKAY;
		end else begin
			aw_hold_q     <= aw_hold_d;
			aw_addr_q     <= aw_addr_d;
			w_hold_q      <= w_hold_d;
			w_data_q      <= w_data_d;
			w_lane0_q     <= w_lane0_d;
			ctrl_q        <= ctrl_d;
			s_axi_awready <= awready_d;
			s_axi_wready  <= wready_d;
			s_axi_bvalid  <= bvalid_d;
			s_axi_bresp   <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid  <= rvalid_d;
			s_axi_rdata   <= rdata_d;
			s_axi_rresp   <= rresp_d;
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_enter;
		state_q == SMC_RUN && halt_exec && ctrl_q.standby_select_bit;
	endsequence
	sequence s_asleep;
		state_q != SMC_RUN;
	endsequence

	a_halt_enters_standby: assert property (s_enter |=> state_q == SMC_STANDBY)
		else $error("Halt with select bit did not enter standby");
	a_halt_sleep_stays: assert property (
		state_q == SMC_RUN && halt_exec && !ctrl_q.standby_select_bit |=> state_q == SMC_RUN)
		else $error("Halt without select bit left run");
	a_standby_all_stopped: assert property (s_asleep |-> !power_q.cpu_run && !power_q.sys_clk_run
		&& !power_q.module_clk_run)
		else $error("Clock or CPU running outside run state");
	a_entry_init_pulse: assert property (s_enter |=> init_q == '1 ##1 init_q == '0)
		else $error("Entry did not give a single init pulse");
	a_ctrl_reg_held: assert property (s_asleep ##1 s_asleep |-> $stable(ctrl_q))
		else $error("Control register changed during standby");
	a_port_float_follow: assert property (s_asleep |-> power_q.port_float == ctrl_q.port_float_bit)
		else $error("Port float does not follow float bit");
	a_no_stray_wake: assert property (state_q == SMC_STANDBY && !wake_edge && rst_lvl_n
		|=> state_q == SMC_STANDBY)
		else $error("Standby left without wake event");
	a_settle_wdt_only: assert property (state_q == SMC_SETTLE |-> power_q.wdt_clk_run
		&& !power_q.sys_clk_run)
		else $error("Settling clock distribution wrong");
	a_overflow_resumes: assert property (state_q == SMC_SETTLE && rst_lvl_n && wdt_overflow_flag
		|=> state_q == SMC_RUN && nmi_exception_q && power_q.cpu_run)
		else $error("Overflow did not resume the chip");
	a_reset_por_exit: assert property (s_asleep and (!rst_lvl_n && nmi_lvl)
		|=> reset_req_q.power_on && !reset_req_q.manual && state_q == SMC_RUN)
		else $error("Power-on reset exit wrong");
	a_reset_manual_exit: assert property (s_asleep and (!rst_lvl_n && !nmi_lvl)
		|=> reset_req_q.manual && !reset_req_q.power_on && state_q == SMC_RUN)
		else $error("Manual reset exit wrong");
	a_rise_ignored_fall: assert property (state_q == SMC_STANDBY && !edge_sel_q && nmi_rise
		&& rst_lvl_n |=> state_q == SMC_STANDBY)
		else $error("Rising edge woke with falling select");
	a_select_refused: assert property (commit && wdt_run_bit && !ctrl_q.standby_select_bit
		|=> !ctrl_q.standby_select_bit)
		else $error("Select bit set while watchdog runs");
endmodule
`default_nettype wire
